// ===== src/rfs_top.sv
// Four-stage residual fault control with Wishbone registers and rolling logs.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
module rfs_top #(
   parameter int TICK_CYC = `RFS_TICK_CYC,  // Clock cycles per 5 ms program cycle.
   parameter int MS_CYC   = `RFS_MS_CYC     // Clock cycles per millisecond.
) (
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic [15:0] measured_current_in,
   input  wire logic [15:0] harmonic_to_fundamental_ratio_in,
   input  wire logic [2:0]  fault_type_in,
   input  wire logic [3:0]  external_block_in,
   output logic      [3:0]  start_out,
   output logic      [3:0]  trip_out,
   output logic      [3:0]  blocked_out,
   output logic      [11:0] event_on_out,
   output logic      [11:0] event_off_out,
   output logic      [31:0] event_stamp_out
);
   import rfs_pkg::*;
   localparam int ST = `RFS_STAGES;

   rfs_log_if lg ();

   // Log and history storage.
   rfs_log_mem u_mem (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .lg       (lg)
   );

   logic [31:0] tick_cnt, next_tick_cnt;     // Program cycle divider.
   logic        tick, next_tick;             // Program cycle start pulse.
   logic        eval, next_eval;             // Decision cycle after sampling.
   logic [31:0] ms_cnt, next_ms_cnt;         // Millisecond divider.
   logic [31:0] stamp, next_stamp;           // Time stamp in milliseconds.
   logic [3:0]  blk_smp, next_blk_smp;       // Block held for a whole cycle.
   logic [15:0] meas_smp, next_meas_smp;     // Current held for a whole cycle.
   logic [15:0] ratio_smp, next_ratio_smp;   // Harmonic ratio, 0.01 % units.
   logic [2:0]  fault_smp, next_fault_smp;   // Fault type held for a cycle.

   // Dividers and the once-per-cycle sampling of the inputs.
   always_comb begin
      next_tick      = 1'b0;
      next_tick_cnt  = tick_cnt + 32'h1;
      if (tick_cnt == 32'(TICK_CYC - 1)) begin
         next_tick_cnt = 32'h0;
         next_tick     = 1'b1;
      end
      next_eval   = tick;
      next_stamp  = stamp;
      next_ms_cnt = ms_cnt + 32'h1;
      if (ms_cnt == 32'(MS_CYC - 1)) begin
         next_ms_cnt = 32'h0;
         next_stamp  = stamp + 32'h1;
      end
      next_blk_smp   = blk_smp;
      next_meas_smp  = meas_smp;
      next_ratio_smp = ratio_smp;
      next_fault_smp = fault_smp;
      if (tick) begin
         next_blk_smp   = external_block_in;
         next_meas_smp  = measured_current_in;
         next_ratio_smp = harmonic_to_fundamental_ratio_in;
         next_fault_smp = fault_type_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_cnt  <= 32'h0;
         tick      <= 1'b0;
         eval      <= 1'b0;
         ms_cnt    <= 32'h0;
         stamp     <= 32'h0;
         blk_smp   <= 4'h0;
         meas_smp  <= 16'h0000;
         ratio_smp <= 16'h0000;
         fault_smp <= 3'h0;
      end else begin
         tick_cnt  <= next_tick_cnt;
         tick      <= next_tick;
         eval      <= next_eval;
         ms_cnt    <= next_ms_cnt;
         stamp     <= next_stamp;
         blk_smp   <= next_blk_smp;
         meas_smp  <= next_meas_smp;
         ratio_smp <= next_ratio_smp;
         fault_smp <= next_fault_smp;
      end
   end

   // The history takes one sample per program cycle, in the decision cycle.
   assign lg.hist_we  = eval;
   assign lg.hist_din = meas_smp;

   logic        req, wr;                     // Bus request and write strobe.
   logic [31:0] wmask;                       // Byte lanes expanded to bits.
   logic [31:0] ctrl, next_ctrl;             // Event mask and setting group.
   logic [31:0] lsel, next_lsel;             // Log read selector.
   logic [31:0] rd;                          // Read data before the register.
   logic [31:0] set_reg  [ST];               // Pick-up level and delay.
   logic [31:0] opt_reg  [ST];               // Inrush, curve and forcing.
   logic [31:0] stat_rd  [ST];               // Status readback.
   logic [31:0] cnt_rd   [ST];               // Counter readback.
   logic [3:0]  wp_rd    [ST];               // Next log slot per stage.
   logic [4:0]  slot_sum;                    // Newest-first slot arithmetic.
   logic [1:0]  stg;                         // Stage addressed on the bus.

   assign req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wr    = req & wb_we_in;
   assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}},
                   {8{wb_sel_in[0]}}};
   assign stg   = 2'((wb_adr_in - `RFS_STAGE_BASE) >> 4);

   // Global registers; an index past the log depth is held at the oldest slot.
   always_comb begin
      next_ctrl = ctrl;
      next_lsel = lsel;
      if (wr && wb_adr_in == `RFS_CTRL_OFS) begin
         next_ctrl = ((ctrl & ~wmask) | (wb_dat_in & wmask)) & `RFS_CTRL_MASK;
      end
      if (wr && wb_adr_in == `RFS_LOG_SEL_OFS) begin
         next_lsel = ((lsel & ~wmask) | (wb_dat_in & wmask)) & `RFS_SEL_MASK;
         if (next_lsel[7:4] > 4'(`RFS_LOG_DEPTH - 1)) begin
            next_lsel[7:4] = 4'(`RFS_LOG_DEPTH - 1);
         end
      end
   end

   // Index zero reads the newest record of the selected stage.
   always_comb begin
      slot_sum = 5'(wp_rd[lsel[1:0]]) + 5'(`RFS_LOG_DEPTH - 1) - 5'(lsel[7:4]);
      if (slot_sum >= 5'(`RFS_LOG_DEPTH)) begin
         slot_sum = slot_sum - 5'(`RFS_LOG_DEPTH);
      end
   end
   assign lg.rd_stage = lsel[1:0];
   assign lg.rd_slot  = slot_sum[3:0];

   // Read multiplexer; unmapped addresses answer with zero.
   always_comb begin
      rd = 32'h0;
      case (wb_adr_in)
         `RFS_CTRL_OFS:    rd = ctrl;
         `RFS_LOG_SEL_OFS: rd = lsel;
         `RFS_LOG0_OFS:    rd = lg.rd_rec.stamp;
         `RFS_LOG1_OFS:    rd = {23'h0, lg.rd_rec.group, lg.rd_rec.fault, lg.rd_rec.evt};
         `RFS_LOG2_OFS:    rd = {lg.rd_rec.fault_cur, lg.rd_rec.pre_trig};
         `RFS_LOG3_OFS:    rd = {lg.rd_rec.remain, lg.rd_rec.pre_fault};
         `RFS_TIME_OFS:    rd = stamp;
         default: begin
            if (wb_adr_in >= `RFS_STAGE_BASE &&
                wb_adr_in < 8'(`RFS_STAGE_BASE + ST * `RFS_STAGE_STRIDE)) begin
               case (wb_adr_in[3:2])
                  `RFS_SET_OFS:  rd = set_reg[stg];
                  `RFS_OPT_OFS:  rd = opt_reg[stg];
                  `RFS_STAT_OFS: rd = stat_rd[stg];
                  default:       rd = cnt_rd[stg];
               endcase
            end
         end
      endcase
   end

   // Bus answer one cycle after the request, dropped the cycle after.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl       <= `RFS_CTRL_RST;
         lsel       <= 32'h0;
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0;
      end else begin
         ctrl       <= next_ctrl;
         lsel       <= next_lsel;
         wb_ack_out <= req;
         wb_dat_out <= req ? rd : 32'h0;
      end
   end

   logic [2:0]  stat    [ST];                // Start, trip, blocked after forcing.
   logic [2:0]  prev    [ST];                // Status one cycle earlier.
   logic [11:0] next_on, next_off;           // Masked event pulses.

   // Independent stages, each with its own registers, timing, counters and log.
   for (genvar s = 0; s < ST; s++) begin : g_stage
      localparam logic [7:0] A_SET = 8'(`RFS_STAGE_BASE + s * `RFS_STAGE_STRIDE);
      localparam logic [7:0] A_OPT = A_SET + 8'h04;
      localparam logic [7:0] A_CNT = A_SET + 8'h0c;
      rfs_state_type st, next_st;            // Protection state.
      logic        pick, next_pick;          // Pick-up with hysteresis.
      logic [31:0] acc, next_acc;            // Delay accumulator.
      logic [15:0] elap, next_elap;          // Ticks since start.
      logic [31:0] next_set, next_opt;       // Register next values.
      logic [2:0]  next_stat;                // Status next value.
      logic [7:0]  cnt [3];                  // Start, trip, blocked counters.
      logic [7:0]  next_cnt [3];
      logic [3:0]  wp, next_wp;              // Next log slot.
      logic [15:0] pf, next_pf;              // Current 200 ms before start.
      logic [2:0]  on, off;                  // Edges of the status.
      logic        blk, hi, lo;              // Effective block, level compares.
      logic [15:0] lvl, dly;                 // Pick-up level and delay setting.
      logic [31:0] target, inc;              // Delay target and step.
      rfs_force_type frc;                    // Forced status selection.

      assign lvl    = set_reg[s][15:0];
      assign dly    = set_reg[s][31:16];
      assign frc    = rfs_force_type'(opt_reg[s][`RFS_F_FORCE_LSB +: 2]);
      assign blk    = blk_smp[s] | (opt_reg[s][`RFS_F_INRUSH] &&
                      ratio_smp > opt_reg[s][15:0]);
      assign hi     = meas_smp > lvl;
      assign lo     = 24'(meas_smp) * `RFS_PCT_FULL < 24'(lvl) * `RFS_HYST_PCT;
      // Inverse time scales the delay by level over current; a floor of one tick remains.
      assign target = opt_reg[s][`RFS_F_IDMT] ? 32'(dly) * 32'(lvl) : 32'(dly);
      assign inc    = opt_reg[s][`RFS_F_IDMT] ? 32'(meas_smp) : 32'h1;
      assign on     = stat[s] & ~prev[s];
      assign off    = ~stat[s] & prev[s];

      // Settings, state machine, counters and log pointer.
      always_comb begin
         next_set  = set_reg[s];
         next_opt  = opt_reg[s];
         if (wr && wb_adr_in == A_SET) begin
            next_set = (set_reg[s] & ~wmask) | (wb_dat_in & wmask);
         end
         if (wr && wb_adr_in == A_OPT) begin
            next_opt = ((opt_reg[s] & ~wmask) | (wb_dat_in & wmask)) & `RFS_OPT_MASK;
         end
         next_st   = st;
         next_pick = pick;
         next_acc  = acc;
         next_elap = elap;
         if (eval) begin
            next_pick = pick ? ~lo : hi;
            next_acc  = 32'h0;
            next_elap = 16'h0000;
            case (st)
               RFS_IDLE: begin
                  if (next_pick) begin
                     next_st = blk ? RFS_BLOCKED : RFS_START;
                  end
               end
               RFS_START: begin
                  if (!next_pick) begin
                     next_st = RFS_IDLE;
                  end else if (blk) begin
                     next_st = RFS_BLOCKED;
                  end else if (acc + inc >= target) begin
                     next_st = RFS_TRIP;
                  end else begin
                     next_acc  = acc + inc;
                     next_elap = elap + 16'h1;
                  end
               end
               RFS_TRIP: begin
                  if (!next_pick) begin
                     next_st = RFS_IDLE;
                  end
               end
               RFS_BLOCKED: begin
                  if (!next_pick) begin
                     next_st = RFS_IDLE;
                  end else if (!blk) begin
                     next_st = RFS_START;
                  end
               end
               default: next_st = RFS_IDLE;
            endcase
         end
         case (frc)
            RFS_FORCE_START:   next_stat = 3'h1;
            RFS_FORCE_TRIP:    next_stat = 3'h3;
            RFS_FORCE_BLOCKED: next_stat = 3'h4;
            default: next_stat = {st == RFS_BLOCKED, st == RFS_TRIP,
                                  st == RFS_START || st == RFS_TRIP};
         endcase
         // A count on the clearing cycle survives as one.
         for (int k = 0; k < 3; k++) begin
            next_cnt[k] = cnt[k];
            if (wr && wb_adr_in == A_CNT && wb_sel_in[0] && wb_dat_in[k]) begin
               next_cnt[k] = 8'h00;
            end
            if (on[k]) begin
               next_cnt[k] = next_cnt[k] + 8'h01;
            end
         end
         next_wp = wp;
         if (|on) begin
            next_wp = (wp == 4'(`RFS_LOG_DEPTH - 1)) ? 4'h0 : wp + 4'h1;
         end
         next_pf = on[0] ? lg.tap_far : pf;
      end

      // Record of the ON edge; trip outranks block, block outranks start.
      always_comb begin
         lg.wr_en[s]             = |on;
         lg.wr_slot[s]           = wp;
         lg.wr_rec[s].stamp      = stamp;
         lg.wr_rec[s].evt        = on[1] ? RFS_EVT_TRIP : on[2] ? RFS_EVT_BLOCK : RFS_EVT_START;
         lg.wr_rec[s].fault      = fault_smp;
         lg.wr_rec[s].group      = ctrl[`RFS_F_GROUP_LSB +: 3];
         lg.wr_rec[s].pre_trig   = lg.tap_near;
         lg.wr_rec[s].fault_cur  = meas_smp;
         lg.wr_rec[s].pre_fault  = on[0] ? lg.tap_far : pf;
         lg.wr_rec[s].remain     = (st == RFS_START && dly > elap) ? dly - elap : 16'h0000;
      end

      assign stat_rd[s] = {lg.wr_rec[s].remain, 13'h0, stat[s]};
      assign cnt_rd[s]  = {8'h00, cnt[2], cnt[1], cnt[0]};
      assign wp_rd[s]   = wp;

      always_ff @(posedge clock_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            set_reg[s] <= `RFS_SET_RST;
            opt_reg[s] <= `RFS_OPT_RST;
            st         <= RFS_IDLE;
            pick       <= 1'b0;
            acc        <= 32'h0;
            elap       <= 16'h0000;
            stat[s]    <= 3'h0;
            prev[s]    <= 3'h0;
            cnt        <= '{default: 8'h00};
            wp         <= 4'h0;
            pf         <= 16'h0000;
         end else begin
            set_reg[s] <= next_set;
            opt_reg[s] <= next_opt;
            st         <= next_st;
            pick       <= next_pick;
            acc        <= next_acc;
            elap       <= next_elap;
            stat[s]    <= next_stat;
            prev[s]    <= stat[s];
            cnt        <= next_cnt;
            wp         <= next_wp;
            pf         <= next_pf;
         end
      end

      // Status pins drive relays and user logic alike.
      assign start_out[s]   = stat[s][0];
      assign trip_out[s]    = stat[s][1];
      assign blocked_out[s] = stat[s][2];
      // Event bit s*3+k names stage s and kind k.
      assign next_on[s*3 +: 3]  = on & {3{ctrl[`RFS_F_MASK_ON]}};
      assign next_off[s*3 +: 3] = off & {3{ctrl[`RFS_F_MASK_OFF]}};
   end

   // Event pulses share one stamp taken in the cycle of the edge.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         event_on_out    <= 12'h000;
         event_off_out   <= 12'h000;
         event_stamp_out <= 32'h0;
      end else begin
         event_on_out    <= next_on;
         event_off_out   <= next_off;
         event_stamp_out <= stamp;
      end
   end
endmodule

// ===== inc/rfs_consts.svh
// Constants of the residual fault stage controller.
// Functional notes
// - Sample external block once per program cycle.
// - Unblocked pick-up raises start, starts delay timing.
// - Optional second-harmonic inrush block, default off.
// - Inrush blocks when ratio exceeds 0.01-percent limit.
// - Blocked pick-up raises blocked, no further processing.
// - Block during start drops start, releases timing.
// - Delay selectable: definite time or inverse time.
// - Four independent stages, events name their stage.
// - Rise and fall events for start, trip, block.
// - Mask selects ON, OFF or both events.
// - Every event carries a time stamp.
// - Clearable counters of start, trip, blocked.
// - Rolling log of twelve records, oldest overwritten.
// - Log captured only on ON edges.
// - Log record fields: stamp, event, currents, group.
// - Status outputs feed pins and user logic.
// - Pick-up when current exceeds pick-up level.
// - Pick-up releases below 97 percent of level.
// - Forcing overrides status for test.
// - Measurements refreshed every 5 ms.
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH
`define RFS_STAGES          4
`define RFS_LOG_DEPTH       12
`define RFS_HIST_DEPTH      64
`define RFS_CLK_HZ          100000000
`define RFS_TICK_MS         5
`define RFS_MS_CYC          (`RFS_CLK_HZ / 1000)
`define RFS_TICK_CYC        (`RFS_MS_CYC * `RFS_TICK_MS)
`define RFS_PRE_TRIG_MS     20
`define RFS_PRE_FAULT_MS    200
`define RFS_PRE_TRIG_TICKS  (`RFS_PRE_TRIG_MS / `RFS_TICK_MS)
`define RFS_PRE_FAULT_TICKS (`RFS_PRE_FAULT_MS / `RFS_TICK_MS)
`define RFS_HYST_PCT        24'h61
`define RFS_PCT_FULL        24'h64
`define RFS_CTRL_OFS        8'h00
`define RFS_LOG_SEL_OFS     8'h04
`define RFS_LOG0_OFS        8'h08
`define RFS_LOG1_OFS        8'h0c
`define RFS_LOG2_OFS        8'h10
`define RFS_LOG3_OFS        8'h14
`define RFS_TIME_OFS        8'h18
`define RFS_STAGE_BASE      8'h20
`define RFS_STAGE_STRIDE    8'h10
`define RFS_SET_OFS         2'h0
`define RFS_OPT_OFS         2'h1
`define RFS_STAT_OFS        2'h2
`define RFS_CNT_OFS         2'h3
`define RFS_CTRL_RST        32'h0000_0003
`define RFS_CTRL_MASK       32'h0000_001f
`define RFS_F_MASK_ON       0
`define RFS_F_MASK_OFF      1
`define RFS_F_GROUP_LSB     2
`define RFS_F_SEL_IDX_LSB   4
`define RFS_SEL_MASK        32'h0000_00f3
`define RFS_SET_RST         32'h0014_0078
`define RFS_OPT_RST         32'h0000_0001
`define RFS_OPT_MASK        32'h000f_ffff
`define RFS_F_INRUSH        16
`define RFS_F_IDMT          17
`define RFS_F_FORCE_LSB     18
`endif

// ===== inc/rfs_pkg.sv
// Types shared by the residual fault stage controller.
`include "rfs_consts.svh"
package rfs_pkg;
   // Protection state of one stage.
   typedef enum logic [1:0] {RFS_IDLE, RFS_START, RFS_TRIP, RFS_BLOCKED} rfs_state_type;
   // Forced status selection for testing.
   typedef enum logic [1:0] {RFS_FORCE_NORMAL, RFS_FORCE_START, RFS_FORCE_TRIP,
                             RFS_FORCE_BLOCKED} rfs_force_type;
   // Event name stored in a log record.
   typedef enum logic [2:0] {RFS_EVT_NONE, RFS_EVT_START, RFS_EVT_TRIP,
                             RFS_EVT_BLOCK} rfs_event_type;
   // One log record.
   typedef struct packed {
      logic [31:0]   stamp;      // Milliseconds since reset.
      rfs_event_type evt;        // Event name.
      logic [2:0]    fault;      // Fault type code.
      logic [2:0]    group;      // Setting group minus one.
      logic [15:0]   pre_trig;   // Current 20 ms before the event.
      logic [15:0]   fault_cur;  // Current at the event.
      logic [15:0]   pre_fault;  // Current 200 ms before start.
      logic [15:0]   remain;     // Remaining trip time in 5 ms ticks.
   } rfs_rec_type;
endpackage

// ===== inc/rfs_log_if.sv
// Interface between the stage controller and its log and history memory.
interface rfs_log_if;
   import rfs_pkg::*;
   logic [`RFS_STAGES-1:0]                wr_en;     // Record write per stage.
   logic [`RFS_STAGES-1:0][3:0]           wr_slot;   // Slot written per stage.
   rfs_rec_type [`RFS_STAGES-1:0]         wr_rec;    // Record per stage.
   logic [1:0]                            rd_stage;  // Stage being read.
   logic [3:0]                            rd_slot;   // Slot being read.
   rfs_rec_type                           rd_rec;    // Registered read record.
   logic                                  hist_we;   // New current sample.
   logic [15:0]                           hist_din;  // Sample value.
   logic [15:0]                           tap_near;  // Sample 20 ms old.
   logic [15:0]                           tap_far;   // Sample 200 ms old.
   modport ctrl (output wr_en, wr_slot, wr_rec, rd_stage, rd_slot, hist_we, hist_din,
                 input rd_rec, tap_near, tap_far);
   modport mem  (input wr_en, wr_slot, wr_rec, rd_stage, rd_slot, hist_we, hist_din,
                 output rd_rec, tap_near, tap_far);
endinterface

// ===== src/rfs_log_mem.sv
// Log banks per stage and current history ring with registered reads.
module rfs_log_mem (
   input  wire logic  clock_in,
   input  wire logic  rst_b_in,
   rfs_log_if.mem     lg
);
   import rfs_pkg::*;
   localparam int ST = `RFS_STAGES;
   localparam int HD = `RFS_HIST_DEPTH;
   rfs_rec_type [ST-1:0] pick;                // Unregistered read of each bank.
   logic [15:0]          hist [HD];           // Current history ring.
   logic [5:0]           hp, next_hp;         // Next history slot to write.

   // One bank per stage so that all stages may log in the same cycle.
   for (genvar s = 0; s < ST; s++) begin : g_bank
      rfs_rec_type bank [`RFS_LOG_DEPTH];
      always_ff @(posedge clock_in) begin
         if (lg.wr_en[s]) begin
            bank[lg.wr_slot[s]] <= lg.wr_rec[s];
         end
      end
      assign pick[s] = bank[lg.rd_slot];
   end

   // History pointer advances once per fresh sample.
   always_comb begin
      next_hp = lg.hist_we ? hp + 6'h01 : hp;
   end

   // Taps are read before the write lands, so hp minus N is N samples back.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hp          <= 6'h00;
         lg.rd_rec   <= '0;
         lg.tap_near <= 16'h0000;
         lg.tap_far  <= 16'h0000;
      end else begin
         hp          <= next_hp;
         lg.rd_rec   <= pick[lg.rd_stage];
         lg.tap_near <= hist[hp - 6'(`RFS_PRE_TRIG_TICKS)];
         lg.tap_far  <= hist[hp - 6'(`RFS_PRE_FAULT_TICKS)];
      end
   end

   // History storage holds no reset; it is only ever read behind the pointer.
   always_ff @(posedge clock_in) begin
      if (lg.hist_we) begin
         hist[hp] <= lg.hist_din;
      end
   end
endmodule

// ===== verif/rfs_properties.sv
// Port checks of the residual fault stage controller.
module rfs_properties #(parameter int TICK_CYC = 50, parameter int MS_CYC = 10) (
   input wire logic        clock_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_ack_out,
   input wire logic [31:0] wb_dat_out,
   input wire logic [3:0]  start_out, trip_out, blocked_out,
   input wire logic [11:0] event_on_out, event_off_out);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // Bus answers come exactly one cycle after a request is taken.
   ack_after_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("request not answered");
   ack_single_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   dat_idle_zero_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
      else $error("read data without ack");
   trip_with_start_a: assert property (trip_out[0] |-> start_out[0])
      else $error("trip without start");
   block_no_start_a: assert property (blocked_out[1] |-> !start_out[1])
      else $error("start while blocked");
   // Events trail the status outputs by one cycle.
   start_on_evt_a: assert property ($rose(start_out[0]) |=> event_on_out[0])
      else $error("start on event missing");
   trip_off_evt_a: assert property ($fell(trip_out[0]) |=> event_off_out[1])
      else $error("trip off event missing");
   block_on_evt_a: assert property ($rose(blocked_out[1]) |=> event_on_out[5])
      else $error("block on event missing");
   cover property ($rose(trip_out[0]));
   cover property ($rose(blocked_out[2]));
   cover property ($fell(start_out[1]));
endmodule
bind rfs_top rfs_properties #(.TICK_CYC(TICK_CYC), .MS_CYC(MS_CYC)) props (
   .clock_in(clock_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .start_out(start_out),
   .trip_out(trip_out), .blocked_out(blocked_out), .event_on_out(event_on_out),
   .event_off_out(event_off_out));

// ===== verif/rfs_far_model.sv
// Blocking matrix and 5 ms measurement front end in front of the stages.
module rfs_far_model #(parameter int TICK_CYC = 50) (
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic [15:0] cur_in, harm_in,
   input  wire logic [3:0]  blk_in,
   output logic      [15:0] cur_out, harm_out,
   output logic      [3:0]  blk_out);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt; // Cycles since the last refresh.
   // Current and ratio only move once per program cycle, as a real front end would; the block passes straight through.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt <= 0;
         cur_out <= 16'h0;
         harm_out <= 16'h0;
      end else begin
         cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
         if (cnt == 0) begin
            cur_out <= cur_in;
            harm_out <= harm_in;
         end
      end
   end
   // Each stage gets its own routed line, set well ahead of any delay expiry.
   assign blk_out = blk_in;
endmodule

// ===== verif/test_rfs_top.sv
// Self-checking bench of the residual fault stage controller.
module test_rfs_top;
   import rfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 50; // Short program cycle.
   logic clk, rst_b, cyc, stb, we, ack;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q, es;
   logic [15:0] cur, harm, mcur, mharm;
   logic [3:0] blk, mblk, st, tr, bl;
   int err_count, n_checks;
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   rfs_far_model #(.TICK_CYC(TK)) far (.clock_in(clk), .rst_b_in(rst_b), .cur_in(cur),
      .harm_in(harm), .blk_in(blk), .cur_out(mcur), .harm_out(mharm), .blk_out(mblk));
   rfs_top #(.TICK_CYC(TK), .MS_CYC(10)) DUT (.clock_in(clk), .rst_b_in(rst_b),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .measured_current_in(mcur),
      .harmonic_to_fundamental_ratio_in(mharm), .fault_type_in(3'h5),
      .external_block_in(mblk), .start_out(st), .trip_out(tr), .blocked_out(bl),
      .event_on_out(), .event_off_out(), .event_stamp_out(es));
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled high.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
      if (n >= 20) begin
         err_count++;
         tally_and_finish;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task automatic wt(input int k);
      repeat (k * TK) @(posedge clk);
   endtask
   initial begin
      {rst_b, cyc, stb, we, adr, wdat, cur, harm, blk, err_count, n_checks} = '0;
      repeat (10) @(posedge clk);
      rst_b <= 1;
      rd(8'h00, 32'h3, "ctrl");
      rd(8'h20, 32'h0014_0078, "set0");
      rd(8'h24, 32'h1, "opt0");
      rd(8'hfc, 32'h0, "unmapped");
      bus(1, 8'h20, 32'h0004_0100);
      cur <= 16'h0200;
      wt(3);
      chk("start0", st[0], 1);
      wt(6);
      chk("trip0", {tr[0], st[0]}, 2'b11);
      cur <= 16'h00f9;
      wt(3);
      chk("hold", tr[0], 1);
      cur <= 16'h00f8;
      wt(3);
      chk("release", st[0], 0);
      rd(8'h2c, 32'h0000_0101, "cnt0");
      bus(1, 8'h2c, 32'h7);
      rd(8'h2c, 32'h0, "cnt0 clear");
      bus(1, 8'h04, 32'h0);
      rd(8'h0c, 32'h0000_002a, "log event");
      {cur, harm, blk} <= {16'h0, 16'h00c8, 4'h2};
      bus(1, 8'h44, 32'h0001_0064);
      wt(3);
      cur <= 16'h0200;
      wt(3);
      chk("blocked", bl, 4'b0110);
      chk("started", st, 4'b1001);
      blk <= 4'h0;
      wt(3);
      chk("unblocked", st[1], 1);
      blk <= 4'h2;
      wt(3);
      chk("block in start", {bl[1], st[1]}, 2'b10);
      bus(1, 8'h54, 32'h0008_0001);
      repeat (3) @(posedge clk);
      chk("force trip", tr[3], 1);
      chk("stamp", es, 32'h8a);
      bus(1, 8'h54, 32'h0002_0000);
      wt(6);
      chk("idmt trip", tr[3], 1);
      tally_and_finish;
   end
endmodule
